// file: common/pxi_pkg.sv
// What this block does
// - Selected edge on the interrupt pin sets request flag, bit 0 at 3EH.
// - Pin-level flag, bit 0 at 0FH, reads the interrupt pin level.
// - Ports B and E choose input or output per line by direction register.
// - Bitwise line switched to output drives its held latch at once.
// - Ports C and D switch all four lines together, one control each.
// - Group port switched to output drives its held latch on all pins.
// - Port E direction is a 4-bit register at 27H, reset 0, 1 = output.
// - Bit 2 of 37H sets port C direction, bit 3 sets port D.
// - Ports B-E: read gives pins in input mode, latch in output; writes load latch.
// - After reset C and D output low; B and E are inputs.
package pxi_pkg;
    localparam int PXI_AW = 8;
    localparam int PXI_DW = 4;
    // Register file offsets (control bank)
    localparam logic [7:0] PXI_PIN_LEVEL_ADDR = 8'h0f;
    localparam logic [7:0] PXI_PORT_B_DIR_ADDR = 8'h26;
    localparam logic [7:0] PXI_PORT_E_DIR_ADDR = 8'h27;
    localparam logic [7:0] PXI_GROUP_DIR_ADDR = 8'h37;
    localparam logic [7:0] PXI_IRQ_ADDR = 8'h3e;
    // Port register offsets (data bank)
    localparam logic [7:0] PXI_PORT_E_ADDR = 8'h6f;
    localparam logic [7:0] PXI_KEY_RET_ADDR = 8'h70;
    localparam logic [7:0] PXI_PORT_B_ADDR = 8'h71;
    localparam logic [7:0] PXI_PORT_C_ADDR = 8'h72;
    localparam logic [7:0] PXI_PORT_D_ADDR = 8'h73;
    // Field positions
    localparam int PXI_IRQ_BIT = 0;
    localparam int PXI_LEVEL_BIT = 0;
    localparam int PXI_GRP_C_BIT = 2;
    localparam int PXI_GRP_D_BIT = 3;
    // Reset values
    localparam logic [3:0] PXI_DIR_BIT_RST = 4'h0;
    localparam logic [3:0] PXI_GROUP_DIR_RST = 4'hc;
    localparam logic [3:0] PXI_LATCH_RST = 4'h0;

    // CPU register access, one nibble per cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] wdata;
    } pxi_req_s;

    // One bidirectional 4-bit port at the pins
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } pxi_pin_s;
endpackage

// file: core/pxi_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module pxi_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// file: core/pxi_port_io.sv
`timescale 1ns/1ps
module pxi_port_io
    import pxi_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire pxi_req_s req_i,
    output logic [3:0] rdata_o,
    input wire logic int_pin_i,
    input wire logic int_rise_sel_i,
    input wire logic [3:0] key_return_port_i,
    input wire logic [3:0] bitwise_port_b_i,
    input wire logic [3:0] group_port_c_i,
    input wire logic [3:0] group_port_d_i,
    input wire logic [3:0] bitwise_port_e_i,
    output pxi_pin_s bitwise_port_b_o,
    output pxi_pin_s group_port_c_o,
    output pxi_pin_s group_port_d_o,
    output pxi_pin_s bitwise_port_e_o
);
    typedef struct packed {
        logic [3:0] rdata;
        logic int_prev;
        logic [1:0] settle;
        logic irq;
        logic [3:0] port_b_dir;
        logic [3:0] port_e_direction;
        logic [3:0] group_direction_bits;
        logic [3:0] latch_b;
        logic [3:0] latch_c;
        logic [3:0] latch_d;
        logic [3:0] latch_e;
        pxi_pin_s pin_b;
        pxi_pin_s pin_c;
        pxi_pin_s pin_d;
        pxi_pin_s pin_e;
    } pxi_state_s;

    pxi_state_s state_q;
    pxi_state_s state_d;
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [3:0] sync_c;
    logic [3:0] sync_d;
    logic [3:0] sync_e;
    logic int_sync;
    logic [3:0] dir_c;
    logic [3:0] dir_d;

    // All pin inputs are asynchronous to the CPU clock
    pxi_sync #(.WIDTH(21)) u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .async_i({int_pin_i, key_return_port_i, bitwise_port_b_i,
                  group_port_c_i, group_port_d_i, bitwise_port_e_i}),
        .sync_o({int_sync, sync_a, sync_b, sync_c, sync_d, sync_e})
    );

    // Mix pins and latch per line by direction
    function automatic logic [3:0] port_view(input logic [3:0] dir,
                                             input logic [3:0] latch,
                                             input logic [3:0] pins);
        port_view = (dir & latch) | (~dir & pins);
    endfunction

    // Write strobe for one address
    function automatic logic hit_wr(input pxi_req_s r,
                                    input logic [7:0] a);
        hit_wr = r.wr && (r.addr == a);
    endfunction

    assign dir_c = {4{state_q.group_direction_bits[PXI_GRP_C_BIT]}};
    assign dir_d = {4{state_q.group_direction_bits[PXI_GRP_D_BIT]}};

    // Next state: register writes, reads, edge flag and pin drive
    always_comb begin
        logic edge_seen;
        logic [3:0] dc;
        logic [3:0] dd;
        edge_seen = 1'b0;
        dc = 4'h0;
        dd = 4'h0;
        state_d = state_q;
        state_d.int_prev = int_sync;
        edge_seen = int_rise_sel_i ? (int_sync && !state_q.int_prev)
                                   : (!int_sync && state_q.int_prev);
        // Edges ignored until the synchroniser refills after reset,
        // so a pin held high is no edge; a real one that early is lost
        edge_seen = edge_seen && (&state_q.settle);
        if (!(&state_q.settle)) begin
            state_d.settle = state_q.settle + 2'h1;
        end
        // Clear by write first, so a same-cycle edge still wins
        if (hit_wr(req_i, PXI_IRQ_ADDR)) begin
            state_d.irq = req_i.wdata[PXI_IRQ_BIT];
        end
        if (edge_seen) begin
            state_d.irq = 1'b1;
        end
        if (hit_wr(req_i, PXI_PORT_B_DIR_ADDR)) begin
            state_d.port_b_dir = req_i.wdata;
        end
        if (hit_wr(req_i, PXI_PORT_E_DIR_ADDR)) begin
            state_d.port_e_direction = req_i.wdata;
        end
        if (hit_wr(req_i, PXI_GROUP_DIR_ADDR)) begin
            state_d.group_direction_bits[PXI_GRP_C_BIT] =
                req_i.wdata[PXI_GRP_C_BIT];
            state_d.group_direction_bits[PXI_GRP_D_BIT] =
                req_i.wdata[PXI_GRP_D_BIT];
        end
        if (hit_wr(req_i, PXI_PORT_B_ADDR)) begin
            state_d.latch_b = req_i.wdata;
        end
        if (hit_wr(req_i, PXI_PORT_C_ADDR)) begin
            state_d.latch_c = req_i.wdata;
        end
        if (hit_wr(req_i, PXI_PORT_D_ADDR)) begin
            state_d.latch_d = req_i.wdata;
        end
        if (hit_wr(req_i, PXI_PORT_E_ADDR)) begin
            state_d.latch_e = req_i.wdata;
        end
        // Key-return port has no latch; writes fall through
        // Read mux; unused addresses read zero
        state_d.rdata = 4'h0;
        if (req_i.rd) begin
            unique case (req_i.addr)
                PXI_PIN_LEVEL_ADDR: begin
                    state_d.rdata[PXI_LEVEL_BIT] = int_sync;
                end
                PXI_IRQ_ADDR: state_d.rdata[PXI_IRQ_BIT] = state_q.irq;
                PXI_PORT_B_DIR_ADDR: state_d.rdata = state_q.port_b_dir;
                PXI_PORT_E_DIR_ADDR:
                    state_d.rdata = state_q.port_e_direction;
                PXI_GROUP_DIR_ADDR:
                    state_d.rdata = state_q.group_direction_bits;
                PXI_KEY_RET_ADDR: state_d.rdata = sync_a;
                PXI_PORT_B_ADDR: state_d.rdata = port_view(
                    state_q.port_b_dir, state_q.latch_b, sync_b);
                PXI_PORT_C_ADDR:
                    state_d.rdata = port_view(dir_c, state_q.latch_c, sync_c);
                PXI_PORT_D_ADDR:
                    state_d.rdata = port_view(dir_d, state_q.latch_d, sync_d);
                PXI_PORT_E_ADDR: state_d.rdata = port_view(
                    state_q.port_e_direction, state_q.latch_e, sync_e);
                default: state_d.rdata = 4'h0;
            endcase
        end
        // Held latch driven once line is output
        state_d.pin_b.oe = state_d.port_b_dir;
        state_d.pin_b.out = state_d.latch_b;
        state_d.pin_e.oe = state_d.port_e_direction;
        state_d.pin_e.out = state_d.latch_e;
        // Group drives latch on all four
        dc = {4{state_d.group_direction_bits[PXI_GRP_C_BIT]}};
        dd = {4{state_d.group_direction_bits[PXI_GRP_D_BIT]}};
        state_d.pin_c.oe = dc;
        state_d.pin_c.out = state_d.latch_c;
        state_d.pin_d.oe = dd;
        state_d.pin_d.out = state_d.latch_d;
    end

    // Reset: C and D output low, B and E input
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= '0;
            state_q.port_b_dir <= PXI_DIR_BIT_RST;
            state_q.port_e_direction <= PXI_DIR_BIT_RST;
            state_q.group_direction_bits <= PXI_GROUP_DIR_RST;
            state_q.latch_c <= PXI_LATCH_RST;
            state_q.latch_d <= PXI_LATCH_RST;
            state_q.pin_c.oe <= 4'hf;
            state_q.pin_d.oe <= 4'hf;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdata_o = state_q.rdata;
    assign bitwise_port_b_o = state_q.pin_b;
    assign group_port_c_o = state_q.pin_c;
    assign group_port_d_o = state_q.pin_d;
    assign bitwise_port_e_o = state_q.pin_e;

    a_irq_edge_set: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (int_rise_sel_i && $rose(int_sync) && (&state_q.settle))
        |=> state_q.irq)
        else $error("edge did not set request flag");
    a_level_read: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (req_i.rd && req_i.addr == PXI_PIN_LEVEL_ADDR)
        |=> rdata_o[0] == $past(int_sync))
        else $error("pin level flag wrong");
    a_dir_b_oe: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        hit_wr(req_i, PXI_PORT_B_DIR_ADDR)
        |=> bitwise_port_b_o.oe == $past(req_i.wdata))
        else $error("port B enable not per bit");
    a_out_latch_e: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        $rose(bitwise_port_e_o.oe[0])
        |-> bitwise_port_e_o.out[0] == state_q.latch_e[0])
        else $error("port E latch not driven");
    a_group_c_all: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        group_port_c_o.oe == 4'h0 || group_port_c_o.oe == 4'hf)
        else $error("port C lines split");
    a_group_d_drive: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        $rose(group_port_d_o.oe[0])
        |-> group_port_d_o.out == state_q.latch_d)
        else $error("port D latch not driven");
    a_dir_e_reg: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        hit_wr(req_i, PXI_PORT_E_DIR_ADDR)
        ##1 !hit_wr(req_i, PXI_PORT_E_DIR_ADDR)
        ##1 (req_i.rd && req_i.addr == PXI_PORT_E_DIR_ADDR)
        |=> rdata_o == $past(req_i.wdata, 3))
        else $error("port E direction readback wrong");
    a_group_map: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        hit_wr(req_i, PXI_GROUP_DIR_ADDR)
        |=> group_port_c_o.oe[0] == $past(req_i.wdata[2])
            && group_port_d_o.oe[0] == $past(req_i.wdata[3]))
        else $error("group direction bits mismapped");
    a_latch_read: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (req_i.rd && req_i.addr == PXI_PORT_C_ADDR && dir_c == 4'hf)
        |=> rdata_o == $past(state_q.latch_c))
        else $error("output-mode read not latch");
    a_key_read: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (req_i.rd && req_i.addr == PXI_KEY_RET_ADDR)
        |=> rdata_o == $past(sync_a))
        else $error("key-return read wrong");
    a_reset_out: assert property (
        @(posedge sys_clk_i)
        $fell(reset_i) |-> group_port_c_o.oe == 4'hf
        && group_port_c_o.out == 4'h0 && bitwise_port_b_o.oe == 4'h0)
        else $error("reset port state wrong");
endmodule

// file: sim/pxi_key_model.sv
`timescale 1ns/1ps
// Key matrix seen from the pins: pull-ups, keys pulling lines low
module pxi_key_model
    import pxi_pkg::*;
(
    input wire logic [19:0] keys_i,
    input wire pxi_pin_s [4:1] drv_i,
    output logic [19:0] pins_o
);
    // Open-drain B, C, D can only pull low; E is push-pull
    always_comb begin
        pins_o[3:0] = keys_i[3:0];
        for (int p = 1; p < 4; p++) begin
            pins_o[p*4 +: 4] = keys_i[p*4 +: 4]
                & ~(drv_i[p].oe & ~drv_i[p].out);
        end
        for (int b = 0; b < 4; b++) begin
            pins_o[16+b] = drv_i[4].oe[b] ? drv_i[4].out[b] : keys_i[16+b];
        end
    end
endmodule

// file: sim/port_io_and_ext_interrupt_tb_top.sv
`timescale 1ns/1ps
module port_io_and_ext_interrupt_tb_top;
    import pxi_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    pxi_req_s req = '0;
    logic [3:0] rdata;
    logic int_pin = 1'b0;
    logic rise_sel = 1'b1;
    logic [19:0] keys = 20'hfffff;
    logic [19:0] pins;
    pxi_pin_s [4:1] po;
    logic [3:0] exp_q[$];
    logic pend = 1'b0;
    logic [3:0] e;
    integer seed = 47;
    int error_cnt = 0;
    int comparisons = 0;

    always #4 sys_clk_i = ~sys_clk_i;

    pxi_port_io DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req),
        .rdata_o(rdata), .int_pin_i(int_pin), .int_rise_sel_i(rise_sel),
        .key_return_port_i(pins[3:0]), .bitwise_port_b_i(pins[7:4]),
        .group_port_c_i(pins[11:8]), .group_port_d_i(pins[15:12]),
        .bitwise_port_e_i(pins[19:16]), .bitwise_port_b_o(po[1]),
        .group_port_c_o(po[2]), .group_port_d_o(po[3]),
        .bitwise_port_e_o(po[4]));
    pxi_key_model partner (.keys_i(keys), .drv_i(po), .pins_o(pins));

    task automatic chk(input string n, input logic [7:0] x,
                       input logic [7:0] s);
        comparisons++;
        if (s !== x) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask

    // Read data lands one cycle after the read edge
    always @(posedge sys_clk_i) pend <= req.rd;
    always @(negedge sys_clk_i) begin
        if (pend === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hx;
            chk("rdata", {4'h0, e}, {4'h0, rdata});
        end
    end

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(negedge sys_clk_i);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge sys_clk_i);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [3:0] x);
        @(negedge sys_clk_i);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 4'h0};
        exp_q.push_back(x);
        @(negedge sys_clk_i);
        req <= '0;
    endtask

    // Four random bits from the seeded stream
    function automatic logic [3:0] rnd4();
        rnd4 = 4'($random(seed));
    endfunction

    // Latch first, then direction: the new output lines show the latch
    task automatic bit_port(input int p, input logic [7:0] da,
                            input logic [7:0] pa);
        logic [3:0] l, dir;
        l = rnd4();
        dir = rnd4();
        keys[p*4 +: 4] = rnd4();
        wr(pa, l);
        wr(da, dir);
        chk("bit pins", {dir, l & dir}, {po[p].oe, po[p].out & dir});
        // Read back soon after the write, pins settle meanwhile
        rd(da, dir);
        idle(3);
        rd(pa, (l & dir) | (keys[p*4 +: 4] & ~dir));
    endtask

    task automatic grp(input logic [3:0] g);
        logic [3:0] lc, ld, mc, md;
        lc = rnd4();
        ld = rnd4();
        keys[15:8] = {rnd4(), rnd4()};
        mc = {4{g[2]}};
        md = {4{g[3]}};
        wr(PXI_GROUP_DIR_ADDR, 4'h0);
        wr(PXI_PORT_C_ADDR, lc);
        wr(PXI_PORT_D_ADDR, ld);
        chk("grp in", 8'h00, {po[2].oe, po[3].oe});
        wr(PXI_GROUP_DIR_ADDR, g);
        chk("grp c", {mc, lc & mc}, {po[2].oe, po[2].out & mc});
        chk("grp d", {md, ld & md}, {po[3].oe, po[3].out & md});
        idle(3);
        rd(PXI_PORT_C_ADDR, g[2] ? lc : keys[11:8]);
        rd(PXI_PORT_D_ADDR, g[3] ? ld : keys[15:12]);
        rd(PXI_GROUP_DIR_ADDR, g & 4'hc);
    endtask

    // Only the selected edge sets the flag; the flag clears by writing 0
    task automatic irq(input logic sel);
        rise_sel = sel;
        int_pin = ~sel;
        idle(4);
        wr(PXI_IRQ_ADDR, 4'h0);
        rd(PXI_IRQ_ADDR, 4'h0);
        int_pin = sel;
        idle(4);
        rd(PXI_IRQ_ADDR, 4'h1);
        rd(PXI_PIN_LEVEL_ADDR, {3'b000, sel});
        wr(PXI_IRQ_ADDR, 4'h0);
        int_pin = ~sel;
        idle(4);
        rd(PXI_IRQ_ADDR, 4'h0);
        rd(PXI_PIN_LEVEL_ADDR, {3'b000, ~sel});
        $display("test irq edge %0d done", sel);
    endtask

    task automatic stop_test();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        stop_test();
    end

    initial begin
        idle(6);
        reset_i = 1'b0;
        // Pin struct is out then enable: C and D drive low, B and E float
        chk("rst c", 8'h0f, po[2]);
        chk("rst d", 8'h0f, po[3]);
        chk("rst b", 8'h00, po[1]);
        chk("rst e", 8'h00, po[4]);
        rd(PXI_PORT_E_DIR_ADDR, 4'h0);
        rd(PXI_GROUP_DIR_ADDR, 4'hc);
        rd(PXI_PORT_C_ADDR, 4'h0);
        rd(8'h00, 4'h0);
        $display("test reset done");
        repeat (6) bit_port(4, PXI_PORT_E_DIR_ADDR, PXI_PORT_E_ADDR);
        repeat (6) bit_port(1, PXI_PORT_B_DIR_ADDR, PXI_PORT_B_ADDR);
        $display("test bit ports done");
        for (int g = 0; g < 16; g += 4) grp(g[3:0]);
        $display("test group ports done");
        keys[3:0] = rnd4();
        wr(PXI_KEY_RET_ADDR, ~keys[3:0]);
        idle(3);
        rd(PXI_KEY_RET_ADDR, keys[3:0]);
        $display("test key return done");
        irq(1'b1);
        irq(1'b0);
        // Reset again with the pin high: no false edge may follow
        idle(3);
        rise_sel = 1'b1;
        reset_i = 1'b1;
        idle(6);
        reset_i = 1'b0;
        chk("mid rst c", 8'h0f, po[2]);
        chk("mid rst e", 8'h00, po[4]);
        idle(4);
        rd(PXI_IRQ_ADDR, 4'h0);
        rd(PXI_PORT_E_DIR_ADDR, 4'h0);
        $display("test mid reset done");
        idle(3);
        chk("queue", 8'h00, 8'(exp_q.size()));
        stop_test();
    end
endmodule
